//--- common/eiu_pkg.sv
`default_nettype none
package eiu_pkg;

    // ------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------
    localparam int NUM_LINES   = 3;
    localparam int ADDR_W      = 8;
    localparam int DATA_W      = 32;
    localparam int SYNC_STAGES = 3;

    // ------------------------------------------------------------
    // register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFS_SENSE_CONTROL = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_MASK          = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_FLAGS         = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_EVT_STATUS    = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_EVT_MASK      = 8'h10;

    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int SENSE_FIELD_W = 2;
    localparam int SENSE_BITS    = NUM_LINES * SENSE_FIELD_W;
    localparam int EVT_WAKE_BIT  = NUM_LINES;
    localparam int EVT_BITS      = NUM_LINES + 1;

    localparam logic [7:0] SENSE_CONTROL_RESET = 8'h00;
    localparam logic [7:0] MASK_RESET          = 8'h00;
    localparam logic [7:0] FLAGS_RESET         = 8'h00;
    localparam logic [7:0] EVT_STATUS_RESET    = 8'h00;
    localparam logic [7:0] EVT_MASK_RESET      = 8'h00;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS     = 10;
    localparam int WDT_PERIOD_NS     = 1000;
    localparam int WDT_TICK_CYCLES   = (WDT_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WAKE_SAMPLES      = 2;
    localparam int STARTUP_CYCLES_DEFAULT = 64;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {SENSE_LOW, SENSE_CHANGE, SENSE_FALL, SENSE_RISE} eiu_sense_t;

    typedef enum logic [1:0] {WAKE_RUN, WAKE_WATCH, WAKE_START} eiu_wake_t;

    typedef struct packed {
        logic              psel;
        logic              penable;
        logic              pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [DATA_W-1:0] pwdata;
    } eiu_apb_req_t;

    typedef struct packed {
        logic [DATA_W-1:0] prdata;
        logic              pready;
        logic              pslverr;
    } eiu_apb_rsp_t;

endpackage
`default_nettype wire

//--- hdl/eiu_top.sv
// The placing of the registers and the APB interface to the registers were decided locally.
`timescale 1ns/10ps
`default_nettype none

// Operation
// - pins trigger even when driven as outputs
// - sense field picks low, change, fall, rise
// - sense register bits 5..0, rest zero
// - low level requests while pin low
// - edges seen only while io clock runs
// - power-down wake needs two watchdog samples
// - vanished level wakes but no interrupt
// - global enable and mask gate request
// - pins sampled first; long pulses caught
// - mask register bits 2..0 enable lines
// - edge or change sets line flag
// - flag cleared when routine is entered
// - writing one clears flag, zero keeps
// - flag reads zero in low level mode
module eiu_top #(
    parameter int STARTUP_CYCLES = eiu_pkg::STARTUP_CYCLES_DEFAULT
) (
    input  wire logic                            clock,
    input  wire logic                            resetn,
    input  wire eiu_pkg::eiu_apb_req_t           apb_req,
    output var  eiu_pkg::eiu_apb_rsp_t           apb_rsp,
    input  wire logic [eiu_pkg::NUM_LINES-1:0]   ext_irq_pins,
    input  wire logic                            global_irq_enable,
    input  wire logic [eiu_pkg::NUM_LINES-1:0]   line_irq_ack,
    input  wire logic                            io_clk_run,
    input  wire logic                            power_down,
    output logic      [eiu_pkg::NUM_LINES-1:0]   line_irq_req,
    output logic                                 wakeup_req,
    output logic                                 irq
);
    import eiu_pkg::*;

    // ------------------------------------------------------------
    // functions
    // ------------------------------------------------------------
    function automatic eiu_sense_t sense_of(input logic [7:0] ctl, input int line);
        sense_of = eiu_sense_t'(ctl[line*SENSE_FIELD_W +: SENSE_FIELD_W]);
    endfunction

    function automatic logic [DATA_W-1:0] widen(input logic [7:0] v);
        widen = {24'h000000, v};
    endfunction

    // ------------------------------------------------------------
    // registers and state
    // ------------------------------------------------------------
    logic [7:0]           sense_ctl_reg;
    logic [7:0]           mask_reg;
    logic [7:0]           flags_reg;
    logic [7:0]           flags_next;
    logic [7:0]           evt_status_reg;
    logic [7:0]           evt_status_next;
    logic [7:0]           evt_mask_reg;
    logic [7:0]           rd_capture_reg;
    logic                 rd_status_reg;
    logic [DATA_W-1:0]    prdata_reg;
    logic                 pslverr_reg;

    logic [NUM_LINES-1:0] sync1_reg;
    logic [NUM_LINES-1:0] sync2_reg;
    logic [NUM_LINES-1:0] sync3_reg;
    logic [NUM_LINES-1:0] filt_reg;
    logic [NUM_LINES-1:0] prev_reg;

    logic [NUM_LINES-1:0] edge_hit;
    logic [NUM_LINES-1:0] level_low;
    logic [NUM_LINES-1:0] line_req_next;

    eiu_wake_t            wake_reg;
    logic [1:0]           wake_hits_reg;
    logic [$clog2(STARTUP_CYCLES+1)-1:0] startup_cnt_reg;
    logic [$clog2(WDT_TICK_CYCLES+1)-1:0] wdt_cnt_reg;
    logic                 wdt_tick;
    logic                 wake_event;
    logic                 awake;

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    logic setup_ph;
    logic access_ph;
    logic wr_en;
    logic addr_ok;

    assign setup_ph  = apb_req.psel && !apb_req.penable;
    assign access_ph = apb_req.psel && apb_req.penable;
    assign wr_en     = access_ph && apb_req.pwrite && addr_ok;

    always_comb begin
        case (apb_req.paddr)
            OFS_SENSE_CONTROL,
            OFS_MASK,
            OFS_FLAGS,
            OFS_EVT_STATUS,
            OFS_EVT_MASK: addr_ok = 1'b1;
            default:      addr_ok = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // read data, captured at setup so the output is a flop
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!resetn) begin
            prdata_reg     <= '0;
            pslverr_reg    <= 1'b0;
            rd_capture_reg <= 8'h00;
            rd_status_reg  <= 1'b0;
        end else if (setup_ph) begin
            pslverr_reg    <= !addr_ok;
            rd_status_reg  <= !apb_req.pwrite && (apb_req.paddr == OFS_EVT_STATUS);
            rd_capture_reg <= evt_status_next;
            case (apb_req.paddr)
                OFS_SENSE_CONTROL: prdata_reg <= widen(sense_ctl_reg);
                OFS_MASK:          prdata_reg <= widen(mask_reg);
                OFS_FLAGS:         prdata_reg <= widen(flags_next);
                OFS_EVT_STATUS:    prdata_reg <= widen(evt_status_next);
                OFS_EVT_MASK:      prdata_reg <= widen(evt_mask_reg);
                default:           prdata_reg <= '0;
            endcase
        end
    end

    // zero wait states: every access completes in its first access cycle
    assign apb_rsp.prdata  = prdata_reg;
    assign apb_rsp.pready  = 1'b1;
    assign apb_rsp.pslverr = access_ph && pslverr_reg;

    // ------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!resetn) begin
            sense_ctl_reg <= SENSE_CONTROL_RESET;
        end else if (wr_en && apb_req.paddr == OFS_SENSE_CONTROL) begin
            sense_ctl_reg <= {2'b00, apb_req.pwdata[SENSE_BITS-1:0]};
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            mask_reg <= MASK_RESET;
        end else if (wr_en && apb_req.paddr == OFS_MASK) begin
            mask_reg <= {5'b00000, apb_req.pwdata[NUM_LINES-1:0]};
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            evt_mask_reg <= EVT_MASK_RESET;
        end else if (wr_en && apb_req.paddr == OFS_EVT_MASK) begin
            evt_mask_reg <= {4'h0, apb_req.pwdata[EVT_BITS-1:0]};
        end
    end

    // ------------------------------------------------------------
    // pin synchroniser and agreement filter
    // ------------------------------------------------------------
    // the pad level is sampled, so a pin driven as an output still triggers
    always_ff @(posedge clock) begin
        if (!resetn) begin
            sync1_reg <= '1;
            sync2_reg <= '1;
            sync3_reg <= '1;
        end else begin
            sync1_reg <= ext_irq_pins;
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
        end
    end

    // a change counts only once two stages agree; glitches of one cycle die here
    always_ff @(posedge clock) begin
        if (!resetn) begin
            filt_reg <= '1;
        end else begin
            for (int i = 0; i < NUM_LINES; i++) begin
                if (sync2_reg[i] == sync3_reg[i]) begin
                    filt_reg[i] <= sync3_reg[i];
                end
            end
        end
    end

    // prev tracks always, so edges during a halted io clock are dropped, not deferred
    always_ff @(posedge clock) begin
        if (!resetn) begin
            prev_reg <= '1;
        end else begin
            prev_reg <= filt_reg;
        end
    end

    // ------------------------------------------------------------
    // trigger selection
    // ------------------------------------------------------------
    always_comb begin
        edge_hit  = '0;
        level_low = '0;
        for (int i = 0; i < NUM_LINES; i++) begin
            case (sense_of(sense_ctl_reg, i))
                SENSE_LOW:    level_low[i] = !filt_reg[i];
                SENSE_CHANGE: edge_hit[i]  = io_clk_run && (filt_reg[i] != prev_reg[i]);
                SENSE_FALL:   edge_hit[i]  = io_clk_run && prev_reg[i] && !filt_reg[i];
                SENSE_RISE:   edge_hit[i]  = io_clk_run && !prev_reg[i] && filt_reg[i];
                default:      edge_hit[i]  = 1'b0;
            endcase
        end
    end

    // ------------------------------------------------------------
    // line flags
    // ------------------------------------------------------------
    always_comb begin
        flags_next = flags_reg;
        for (int i = 0; i < NUM_LINES; i++) begin
            if (line_irq_ack[i]) begin
                flags_next[i] = 1'b0;
            end
            if (wr_en && apb_req.paddr == OFS_FLAGS && apb_req.pwdata[i]) begin
                flags_next[i] = 1'b0;
            end
            // set wins over either clear
            if (edge_hit[i]) begin
                flags_next[i] = 1'b1;
            end
            if (sense_of(sense_ctl_reg, i) == SENSE_LOW) begin
                flags_next[i] = 1'b0;
            end
        end
        flags_next[7:NUM_LINES] = '0;
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            flags_reg <= FLAGS_RESET;
        end else begin
            flags_reg <= flags_next;
        end
    end

    // ------------------------------------------------------------
    // requests to the core
    // ------------------------------------------------------------
    // level requests are held off while asleep or starting up; the level must
    // still be there after the start-up time to interrupt
    assign awake = (wake_reg == WAKE_RUN) && !power_down;

    always_comb begin
        for (int i = 0; i < NUM_LINES; i++) begin
            line_req_next[i] = global_irq_enable && mask_reg[i] &&
                               (flags_reg[i] || (level_low[i] && awake));
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            line_irq_req <= '0;
        end else begin
            line_irq_req <= line_req_next & ~line_irq_ack;
        end
    end

    // ------------------------------------------------------------
    // watchdog oscillator tick
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!resetn) begin
            wdt_cnt_reg <= '0;
        end else if (wdt_tick) begin
            wdt_cnt_reg <= '0;
        end else begin
            wdt_cnt_reg <= wdt_cnt_reg + 1'b1;
        end
    end

    assign wdt_tick = (wdt_cnt_reg == ($bits(wdt_cnt_reg))'(WDT_TICK_CYCLES - 1));

    // ------------------------------------------------------------
    // power-down wake sequencer
    // ------------------------------------------------------------
    logic wake_level;
    assign wake_level = global_irq_enable && |(level_low & mask_reg[NUM_LINES-1:0]);

    always_ff @(posedge clock) begin
        if (!resetn) begin
            wake_reg        <= WAKE_RUN;
            wake_hits_reg   <= 2'd0;
            startup_cnt_reg <= '0;
        end else begin
            case (wake_reg)
                WAKE_RUN: begin
                    wake_hits_reg <= 2'd0;
                    if (power_down) begin
                        wake_reg <= WAKE_WATCH;
                    end
                end
                WAKE_WATCH: begin
                    if (!power_down) begin
                        wake_reg <= WAKE_RUN;
                    end else if (wdt_tick) begin
                        if (!wake_level) begin
                            wake_hits_reg <= 2'd0;
                        end else if (wake_hits_reg == 2'(WAKE_SAMPLES - 1)) begin
                            wake_reg        <= WAKE_START;
                            startup_cnt_reg <= '0;
                        end else begin
                            wake_hits_reg <= wake_hits_reg + 2'd1;
                        end
                    end
                end
                WAKE_START: begin
                    // wakes even if the level has gone meanwhile
                    if (startup_cnt_reg == ($bits(startup_cnt_reg))'(STARTUP_CYCLES - 1)) begin
                        wake_reg <= WAKE_RUN;
                    end else begin
                        startup_cnt_reg <= startup_cnt_reg + 1'b1;
                    end
                end
                default: wake_reg <= WAKE_RUN;
            endcase
        end
    end

    assign wake_event = (wake_reg == WAKE_START) &&
                        (startup_cnt_reg == ($bits(startup_cnt_reg))'(STARTUP_CYCLES - 1));

    always_ff @(posedge clock) begin
        if (!resetn) begin
            wakeup_req <= 1'b0;
        end else begin
            wakeup_req <= (wake_reg == WAKE_START);
        end
    end

    // ------------------------------------------------------------
    // event status and interrupt output
    // ------------------------------------------------------------
    // only bits that were actually returned are cleared, so a set arriving
    // between setup and access survives the read
    always_comb begin
        evt_status_next = evt_status_reg;
        if (access_ph && rd_status_reg) begin
            evt_status_next = evt_status_reg & ~rd_capture_reg;
        end
        evt_status_next[NUM_LINES-1:0] = evt_status_next[NUM_LINES-1:0] | edge_hit;
        evt_status_next[EVT_WAKE_BIT]  = evt_status_next[EVT_WAKE_BIT] | wake_event;
        evt_status_next[7:EVT_BITS]    = '0;
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            evt_status_reg <= EVT_STATUS_RESET;
        end else begin
            evt_status_reg <= evt_status_next;
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(evt_status_next & evt_mask_reg);
        end
    end

endmodule // eiu_top
`default_nettype wire

//--- test/eiu_core_model.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// core side: enters the routine of the lowest requesting line
// ----------------------------------------
module eiu_core_model (
    input  wire logic       clock,
    input  wire logic       resetn,
    input  wire logic       ack_en,
    input  wire logic [1:0] ack_lat,
    input  wire logic [2:0] line_irq_req,
    output logic      [2:0] line_irq_ack
);
    logic [1:0] wait_cnt;
    // a repeated ack while the request lags is harmless, the flag is already clear
    always_ff @(posedge clock) begin
        line_irq_ack <= 3'h0;
        wait_cnt <= 2'h0;
        if (resetn && ack_en && line_irq_req != 3'h0) begin
            wait_cnt <= wait_cnt + 2'h1;
            if (wait_cnt == ack_lat) begin
                line_irq_ack <= line_irq_req & (3'h0 - line_irq_req);
                wait_cnt <= 2'h0;
            end
        end
    end
endmodule // eiu_core_model
`default_nettype wire

//--- test/eiu_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module eiu_monitor #(
    parameter int STARTUP_CYCLES = 4
) (
    input wire logic                  clock,
    input wire logic                  resetn,
    input wire eiu_pkg::eiu_apb_req_t apb_req,
    input wire eiu_pkg::eiu_apb_rsp_t apb_rsp,
    input wire logic [2:0]            ext_irq_pins,
    input wire logic                  global_irq_enable,
    input wire logic [2:0]            line_irq_ack,
    input wire logic                  io_clk_run,
    input wire logic                  power_down,
    input wire logic [2:0]            line_irq_req,
    input wire logic                  wakeup_req,
    input wire logic                  irq
);
    import eiu_pkg::*;
    // ----------------------------------------
    // shadow of the written sense and mask registers
    // ----------------------------------------
    logic [5:0]  sense_sh;
    logic [2:0]  mask_sh;
    int unsigned run_cnt;
    wire         acc = apb_req.psel && apb_req.penable;
    wire         rdacc = acc && !apb_req.pwrite;
    wire         wr = acc && apb_req.pwrite;
    wire [2:0]   lowm = {sense_sh[5:4] == 2'h0, sense_sh[3:2] == 2'h0, sense_sh[1:0] == 2'h0};
    wire         lvl_ok = sense_sh[1:0] == 2'h0 && mask_sh[0] && global_irq_enable && !power_down && !wakeup_req;
    always_ff @(posedge clock) begin
        if (!resetn) begin
            sense_sh <= 6'h00;
            mask_sh <= 3'h0;
        end else if (wr && apb_req.paddr == OFS_SENSE_CONTROL) begin
            sense_sh <= apb_req.pwdata[5:0];
        end else if (wr && apb_req.paddr == OFS_MASK) begin
            mask_sh <= apb_req.pwdata[2:0];
        end
    end
    // length of the current start-up window
    always_ff @(posedge clock) begin
        if (!resetn || !wakeup_req) run_cnt <= 0;
        else run_cnt <= run_cnt + 1;
    end
    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);
    sequence low_held_s;
        (lvl_ok && !ext_irq_pins[0]) [*8];
    endsequence
    sequence high_held_s;
        (sense_sh[1:0] == 2'h0 && ext_irq_pins[0]) [*8];
    endsequence
    sense_read_a: assert property (rdacc && apb_req.paddr == OFS_SENSE_CONTROL && $stable(sense_sh)
        |-> apb_rsp.prdata == 32'(sense_sh)) else $error("sense readback wrong");
    mask_read_a: assert property (rdacc && apb_req.paddr == OFS_MASK && $stable(mask_sh)
        |-> apb_rsp.prdata == 32'(mask_sh)) else $error("mask readback wrong");
    low_flag_a: assert property (rdacc && apb_req.paddr == OFS_FLAGS && $stable(sense_sh)
        |-> (apb_rsp.prdata & 32'(lowm)) == 0 && apb_rsp.prdata[31:3] == 0) else $error("flag set in level mode");
    req_gate_a: assert property (line_irq_req != 3'h0 |-> $past(global_irq_enable)
        && (line_irq_req & ~$past(mask_sh)) == 3'h0) else $error("request not gated");
    ack_clear_a: assert property ((line_irq_ack & ~lowm) != 3'h0
        |-> ##2 (line_irq_req & $past(line_irq_ack, 2) & ~lowm) == 3'h0) else $error("ack kept request");
    fall_lat_a: assert property ($fell(ext_irq_pins[0]) && sense_sh[1:0] == 2'h2 && mask_sh[0]
        && global_irq_enable && io_clk_run |-> ##[2:12] line_irq_req[0]) else $error("fall edge missed");
    low_req_a: assert property (low_held_s |-> line_irq_req[0]) else $error("level request missing");
    low_rel_a: assert property (high_held_s |-> !line_irq_req[0]) else $error("level request stuck");
    wake_len_a: assert property ($fell(wakeup_req) |-> run_cnt == STARTUP_CYCLES)
        else $error("start-up length wrong");
    wake_pd_a: assert property ($rose(wakeup_req) |-> $past(power_down))
        else $error("wake outside power-down");
endmodule // eiu_monitor
`default_nettype wire

//--- test/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import eiu_pkg::*;
    logic         clock = 1'b0;
    logic         resetn = 1'b0;
    eiu_apb_req_t apb_req = '0;
    eiu_apb_rsp_t apb_rsp;
    logic [2:0]   pins = 3'h7;
    logic [2:0]   ack;
    logic [2:0]   req;
    logic         gie = 1'b0;
    logic         io_run = 1'b1;
    logic         pd = 1'b0;
    logic         ack_en = 1'b0;
    logic         wake;
    logic         irq;
    logic [31:0]  rd;
    logic         err;
    logic [15:0]  lfsr_s = 16'hC2BB;
    int           error_cnt = 0;
    int           checks = 0;
    int           flag_m;
    always #5 clock = ~clock;
    eiu_top #(.STARTUP_CYCLES(4)) DUT (.clock(clock), .resetn(resetn), .apb_req(apb_req), .apb_rsp(apb_rsp),
        .ext_irq_pins(pins), .global_irq_enable(gie), .line_irq_ack(ack), .io_clk_run(io_run),
        .power_down(pd), .line_irq_req(req), .wakeup_req(wake), .irq(irq));
    eiu_core_model core (.clock(clock), .resetn(resetn), .ack_en(ack_en), .ack_lat(2'h2),
        .line_irq_req(req), .line_irq_ack(ack));
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t read %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_sig(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t output %b expected %b", $time, got, exp);
        end
    endtask
    // zero wait states today, but the loop keeps the master honest
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
        @(posedge clock);
        apb_req.penable <= 1'b1;
        @(posedge clock);
        while (apb_rsp.pready !== 1'b1) @(posedge clock);
        rd = apb_rsp.prdata;
        err = apb_rsp.pslverr;
        apb_req <= '0;
    endtask
    task automatic wr(input logic [7:0] a, input int d);
        apb(1'b1, a, 32'(d));
    endtask
    task automatic rdc(input logic [7:0] a, input int exp);
        apb(1'b0, a, 32'h0);
        chk_reg(rd, 32'(exp));
    endtask
    task automatic close_out;
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        #200000;
        error_cnt++;
        $display("[ERR] %0t watchdog expired", $time);
        close_out();
    end
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial begin
        repeat (8) @(posedge clock);
        resetn <= 1'b1;
        for (int i = 0; i < 5; i++) rdc(8'(4 * i), 0);
        apb(1'b0, 8'h20, 32'h0);
        chk_sig(err, 1'b1);
        chk_reg(rd, 32'h0);
        repeat (4) begin
            lfsr_s = lfsr(lfsr_s);
            wr(OFS_MASK, 0);
            wr(OFS_SENSE_CONTROL, {16'h0, lfsr_s});
            rdc(OFS_SENSE_CONTROL, lfsr_s & 16'h003F);
            wr(OFS_MASK, {16'h0, lfsr_s});
            rdc(OFS_MASK, lfsr_s & 16'h0007);
        end
        wr(OFS_EVT_MASK, 7);
        gie <= 1'b1;
        for (int ln = 0; ln < 3; ln++) for (int md = 1; md < 4; md++) begin
            wr(OFS_MASK, 0);
            wr(OFS_SENSE_CONTROL, md << (2 * ln));
            wr(OFS_FLAGS, 7);
            apb(1'b0, OFS_EVT_STATUS, 32'h0);
            wr(OFS_MASK, 1 << ln);
            pins[ln] <= 1'b0;
            repeat (12) @(posedge clock);
            flag_m = (md != 3) ? (1 << ln) : 0;
            chk_sig(req[ln], flag_m != 0);
            chk_sig(irq, flag_m != 0);
            wr(OFS_FLAGS, 0);
            rdc(OFS_FLAGS, flag_m);
            rdc(OFS_EVT_STATUS, flag_m);
            rdc(OFS_EVT_STATUS, 0);
            pins[ln] <= 1'b1;
            repeat (12) @(posedge clock);
            flag_m |= (md != 2) ? (1 << ln) : 0;
            rdc(OFS_FLAGS, flag_m);
            wr(OFS_FLAGS, 1 << ln);
            rdc(OFS_FLAGS, 0);
        end
        // edges while the io clock is stopped are lost
        io_run <= 1'b0;
        pins[2] <= 1'b0;
        repeat (12) @(posedge clock);
        pins[2] <= 1'b1;
        repeat (12) @(posedge clock);
        io_run <= 1'b1;
        rdc(OFS_FLAGS, 0);
        wr(OFS_EVT_MASK, 0);
        gie <= 1'b0;
        pins[2] <= 1'b0;
        repeat (6) @(posedge clock);
        pins[2] <= 1'b1;
        repeat (12) @(posedge clock);
        chk_sig(req[2], 1'b0);
        chk_sig(irq, 1'b0);
        rdc(OFS_FLAGS, 4);
        rdc(OFS_EVT_STATUS, 4);
        wr(OFS_EVT_MASK, 7);
        ack_en <= 1'b1;
        gie <= 1'b1;
        repeat (12) @(posedge clock);
        chk_sig(req[2], 1'b0);
        rdc(OFS_FLAGS, 0);
        ack_en <= 1'b0;
        wr(OFS_MASK, 0);
        wr(OFS_SENSE_CONTROL, 0);
        wr(OFS_MASK, 1);
        pins[0] <= 1'b0;
        repeat (20) @(posedge clock);
        chk_sig(req[0], 1'b1);
        rdc(OFS_FLAGS, 0);
        pins[0] <= 1'b1;
        repeat (12) @(posedge clock);
        chk_sig(req[0], 1'b0);
        // a low of one tick period spans exactly one watchdog sample: not enough to wake
        pd <= 1'b1;
        pins[0] <= 1'b0;
        repeat (100) @(posedge clock);
        pins[0] <= 1'b1;
        repeat (300) @(posedge clock);
        chk_sig(wake, 1'b0);
        for (int hold = 0; hold < 2; hold++) begin
            pd <= 1'b1;
            pins[0] <= 1'b0;
            for (int n = 0; n < 400 && wake !== 1'b1; n++) @(posedge clock);
            chk_sig(wake, 1'b1);
            pins[0] <= hold == 0;
            for (int n = 0; n < 20 && wake !== 1'b0; n++) @(posedge clock);
            pd <= 1'b0;
            repeat (12) @(posedge clock);
            chk_sig(req[0], hold == 1);
            rdc(OFS_EVT_STATUS, 8);
            pins[0] <= 1'b1;
            repeat (12) @(posedge clock);
        end
        close_out();
    end
endmodule // tb_top
bind eiu_top eiu_monitor #(.STARTUP_CYCLES(STARTUP_CYCLES)) mon (.clock(clock), .resetn(resetn),
    .apb_req(apb_req), .apb_rsp(apb_rsp), .ext_irq_pins(ext_irq_pins), .global_irq_enable(global_irq_enable),
    .line_irq_ack(line_irq_ack), .io_clk_run(io_clk_run), .power_down(power_down),
    .line_irq_req(line_irq_req), .wakeup_req(wakeup_req), .irq(irq));
`default_nettype wire
